/* File: core/swic_defines.svh */
// Constants of the sleep, wake and interrupt control block.
// Assumes inclusion by bare name from the top module.
`ifndef SWIC_DEFINES_SVH
`define SWIC_DEFINES_SVH

// Register indices; byte address is four times the index.
`define SWIC_IDX_STATUS     9'h003
`define SWIC_IDX_IRQ_CTL    9'h00b
`define SWIC_IDX_OPTION     9'h081
`define SWIC_IDX_PWR_CTL    9'h08e

// Bit positions inside the byte-wide registers.
`define SWIC_BIT_EDGE_SEL   6
`define SWIC_BIT_TIMEOUT    4
`define SWIC_BIT_PWRDOWN    3

// Reset values.
`define SWIC_RST_IRQ_CTL    8'h00
`define SWIC_RST_EDGE_SEL   1'b1
`define SWIC_RST_PWR_OK     3'h4
`define SWIC_RST_ARM        3'h0

// Program counter targets.
`define SWIC_VEC_RESET      13'h0000
`define SWIC_VEC_IRQ        13'h0004

// Interrupt latency in instruction cycles after the flag is sampled.
`define SWIC_LAT_CYCLES     2'd3

// Timer roll-over values.
`define SWIC_TMR_MAX        8'hff
`define SWIC_TMR_ZERO       8'h00

`endif

/* File: core/swic_pkg.sv */
// Types of the sleep, wake and interrupt control block.
// Assumes the defines header is on the include path.
package swic_pkg;

	typedef struct packed {
		logic global;
		logic periph_en;
		logic timer_en;
		logic ext_en;
		logic port_en;
		logic timer_flag;
		logic ext_flag;
		logic port_flag;
	} irq_ctl_type;

	typedef struct packed {
		logic       parity_en;
		logic [3:0] unused;
		logic       parity_ok;
		logic       por_ok;
		logic       bor_ok;
	} pwr_ctl_type;

	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} phase_type;

	typedef enum logic [3:0] {
		M_RUN   = 4'b0001,
		M_SLEEP = 4'b0010,
		M_WAKE  = 4'b0100,
		M_LAT   = 4'b1000
	} mode_type;

endpackage : swic_pkg

/* File: core/swic_top.sv */
// Interrupt flags, sleep entry and wake-up, and reset-cause status.
// Assumes an APB master on SYS_CLK and a core that pulses SLEEP_EXEC.
//
// Overview of operation
// - Edge select picks rising or falling pin edge
// - Pin edge wakes only when its enable set
// - Timer roll from max to zero sets flag
// - Upper port-B pin change sets change flag
// - Change coinciding with port read may vanish
// - Vector reached three cycles after flag sampling
// - Flag sampled at first phase each cycle
// - Reset loads zero, interrupt loads four
// - Sleep clears watchdog and powerdown, sets timeout, stops oscillator
// - Pins hold their drive state during sleep
// - Master clear resets; other wake sources resume
// - Powerdown set at power-up; watchdog clears timeout
// - Peripheral wake only from sleep-capable sources
// - Wake ignores global enable; then maybe vector
// - Pending enabled flag turns sleep into no-op
// - Interrupt during sleep: finish sleep, then wake
// - Power-on clears power-on status bit
// - Brown-out clears brown-out status bit
// - Parity reset clears parity status bit
// - Top bit mirrors parity enable, bits 6 to 3 zero
`timescale 1ns/10ps
`include "swic_defines.svh"

module swic_top (
	// Clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        NRST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Pins
	input  wire logic        EXT_IRQ_PIN,
	input  wire logic [3:0]  PORT_B_A,
	input  wire logic        MASTER_CLEAR_N,
	// Core and on-chip sources
	input  wire logic        SLEEP_EXEC,
	input  wire logic        PORT_READ,
	input  wire logic [7:0]  TIMER_ZERO,
	input  wire logic        PERIPH_IRQ,
	input  wire logic        WATCHDOG_TIMEOUT,
	input  wire logic        BROWNOUT_RESET,
	input  wire logic        PARITY_ERROR_RESET,
	input  wire logic        PARITY_CHECK_CFG,
	// Core controls
	output logic             PHASE_Q1,
	output logic             IRQ_REQUEST,
	output logic             PC_LOAD,
	output logic      [12:0] PC_VALUE,
	output logic             CORE_RESET,
	output logic             SLEEP_ACTIVE,
	output logic             IO_HOLD,
	output logic             OSC_DRIVE_EN,
	output logic             WATCHDOG_CLEAR
);

	swic_pkg::irq_ctl_type ctl_q;
	swic_pkg::irq_ctl_type ctl_d;
	swic_pkg::pwr_ctl_type pwr_rd;
	swic_pkg::phase_type   phase_q;
	swic_pkg::phase_type   phase_d;
	swic_pkg::mode_type    mode_q;
	swic_pkg::mode_type    mode_d;
	logic [2:0]  pwr_ok_q;
	logic [1:0]  lat_q;
	logic [1:0]  lat_d;
	logic [7:0]  tmr_prev_q;
	logic [3:0]  port_s1_q;
	logic [3:0]  port_s2_q;
	logic [3:0]  port_prev_q;
	logic [2:0]  arm_q;
	logic        ext_s1_q;
	logic        ext_s2_q;
	logic        ext_prev_q;
	logic        master_clear_pin_s1_q;
	logic        master_clear_pin_s2_q;
	logic        edge_sel_q;
	logic        pd_q;
	logic        to_q;
	logic        boot_q;
	logic        ext_edge;
	logic        tmr_ovf;
	logic        port_chg;
	logic        pend;
	logic        wake_src;
	logic        vector_now;
	logic        sleep_go;
	logic        setup;
	logic        access;
	logic        hit;
	logic        wr_ctl;
	logic        wr_opt;
	logic        wr_pwr;
	logic [7:0]  rd_data;

	function automatic logic is_reg(input logic [11:0] addr,
		input logic [8:0] idx);
		is_reg = (addr == {1'b0, idx, 2'b00});
	endfunction : is_reg

	// Pin synchronisers; only the second stage is read.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			ext_s1_q  <= 1'b0;
			ext_s2_q  <= 1'b0;
			port_s1_q <= 4'h0;
			port_s2_q <= 4'h0;
			master_clear_pin_s1_q <= 1'b1;
			master_clear_pin_s2_q <= 1'b1;
		end
		else
		begin
			ext_s1_q  <= EXT_IRQ_PIN;
			ext_s2_q  <= ext_s1_q;
			port_s1_q <= PORT_B_A;
			port_s2_q <= port_s1_q;
			master_clear_pin_s1_q <= MASTER_CLEAR_N;
			master_clear_pin_s2_q <= master_clear_pin_s1_q;
		end
	end

	// Previous values for edge, change and roll-over detection.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			ext_prev_q  <= 1'b0;
			port_prev_q <= 4'h0;
			tmr_prev_q  <= 8'h00;
		end
		else
		begin
			ext_prev_q  <= ext_s2_q;
			port_prev_q <= port_s2_q;
			tmr_prev_q  <= TIMER_ZERO;
		end
	end

	// The edge and change detectors stay quiet until the synchronisers hold real pin
	// levels, so a pin already high at reset release is not an edge.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
			arm_q <= `SWIC_RST_ARM;
		else
			arm_q <= {arm_q[1:0], 1'b1};
	end

	assign ext_edge = arm_q[2] & (edge_sel_q ? (ext_s2_q & ~ext_prev_q)
		: (~ext_s2_q & ext_prev_q));
	assign tmr_ovf  = (tmr_prev_q == `SWIC_TMR_MAX) &&
		(TIMER_ZERO == `SWIC_TMR_ZERO);
	// A change seen while the port is read in Q2 is dropped, which the
	// core's read-modify-write path tolerates.
	assign port_chg = arm_q[2] && (port_s2_q != port_prev_q) &&
		!(PORT_READ && phase_q == swic_pkg::PH_Q2);

	// Peripheral input carries only sources that run without the phase
	// clocks, so it may wake the device from sleep.
	assign pend = (ctl_q.ext_flag & ctl_q.ext_en) |
		(ctl_q.timer_flag & ctl_q.timer_en) |
		(ctl_q.port_flag & ctl_q.port_en) |
		(PERIPH_IRQ & ctl_q.periph_en);
	assign wake_src = pend | WATCHDOG_TIMEOUT;

	// Four-phase instruction clock; frozen while asleep.
	always_comb
	begin
		phase_d = phase_q;
		if (mode_q != swic_pkg::M_SLEEP)
		begin
			unique case (phase_q)
				swic_pkg::PH_Q1: phase_d = swic_pkg::PH_Q2;
				swic_pkg::PH_Q2: phase_d = swic_pkg::PH_Q3;
				swic_pkg::PH_Q3: phase_d = swic_pkg::PH_Q4;
				swic_pkg::PH_Q4: phase_d = swic_pkg::PH_Q1;
				default:         phase_d = swic_pkg::PH_Q1;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST || !master_clear_pin_s2_q)
			phase_q <= swic_pkg::PH_Q1;
		else
			phase_q <= phase_d;
	end

	// Sleep, wake and vector sequencing.
	always_comb
	begin
		mode_d     = mode_q;
		lat_d      = lat_q;
		vector_now = 1'b0;
		sleep_go   = 1'b0;
		unique case (mode_q)
			swic_pkg::M_RUN:
			begin
				if (SLEEP_EXEC)
				begin
					if (!pend)
					begin
						mode_d   = swic_pkg::M_SLEEP;
						sleep_go = 1'b1;
					end
				end
				else if (ctl_q.global && pend &&
					phase_q == swic_pkg::PH_Q1)
				begin
					mode_d = swic_pkg::M_LAT;
					lat_d  = 2'd0;
				end
			end
			swic_pkg::M_SLEEP:
			begin
				// Sleep is entered first unless an enabled flag is already pending, so a late source
				// still sees the full sleep effects.
				if (wake_src)
					mode_d = swic_pkg::M_WAKE;
			end
			swic_pkg::M_WAKE:
			begin
				// The prefetched instruction runs before any vector.
				if (phase_q == swic_pkg::PH_Q4)
					mode_d = swic_pkg::M_RUN;
			end
			swic_pkg::M_LAT:
			begin
				if (phase_q == swic_pkg::PH_Q1)
				begin
					if (lat_q == `SWIC_LAT_CYCLES - 2'd1)
					begin
						vector_now = 1'b1;
						mode_d     = swic_pkg::M_RUN;
					end
					else
						lat_d = lat_q + 2'd1;
				end
			end
			default: mode_d = swic_pkg::M_RUN;
		endcase
	end

	// Master clear resets the core; the other sources only resume.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST || !master_clear_pin_s2_q)
		begin
			mode_q <= swic_pkg::M_RUN;
			lat_q  <= 2'd0;
		end
		else
		begin
			mode_q <= mode_d;
			lat_q  <= lat_d;
		end
	end

	// Interrupt control: a hardware set beats a software write.
	always_comb
	begin
		ctl_d = ctl_q;
		if (wr_ctl)
			ctl_d = swic_pkg::irq_ctl_type'(PWDATA[7:0]);
		if (vector_now)
			ctl_d.global = 1'b0;
		ctl_d.ext_flag   = ctl_d.ext_flag | ext_edge;
		ctl_d.timer_flag = ctl_d.timer_flag | tmr_ovf;
		ctl_d.port_flag  = ctl_d.port_flag | port_chg;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST || !master_clear_pin_s2_q)
			ctl_q <= swic_pkg::irq_ctl_type'(`SWIC_RST_IRQ_CTL);
		else
			ctl_q <= ctl_d;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST || !master_clear_pin_s2_q)
			edge_sel_q <= `SWIC_RST_EDGE_SEL;
		else if (wr_opt)
			edge_sel_q <= PWDATA[`SWIC_BIT_EDGE_SEL];
	end

	// Powerdown and timeout flags survive master clear, so software
	// can tell the cause of a reset from them.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			pd_q <= 1'b1;
			to_q <= 1'b1;
		end
		else
		begin
			if (sleep_go)
			begin
				pd_q <= 1'b0;
				to_q <= 1'b1;
			end
			if (WATCHDOG_TIMEOUT)
				to_q <= 1'b0;
		end
	end

	// Reset-cause bits: software sets them, a reset event clears them
	// and wins over a write in the same cycle.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
			pwr_ok_q <= `SWIC_RST_PWR_OK;
		else
		begin
			if (wr_pwr)
				pwr_ok_q <= PWDATA[2:0] | pwr_ok_q;
			if (BROWNOUT_RESET)
				pwr_ok_q[0] <= 1'b0;
			if (PARITY_ERROR_RESET)
				pwr_ok_q[2] <= 1'b0;
		end
	end

	// APB decode; one wait-free access phase per transfer.
	assign setup  = PSEL & ~PENABLE;
	assign access = PSEL & PENABLE & PREADY;
	assign hit    = is_reg(PADDR, `SWIC_IDX_STATUS) |
		is_reg(PADDR, `SWIC_IDX_IRQ_CTL) |
		is_reg(PADDR, `SWIC_IDX_OPTION) |
		is_reg(PADDR, `SWIC_IDX_PWR_CTL);
	assign wr_ctl = access & PWRITE & is_reg(PADDR, `SWIC_IDX_IRQ_CTL);
	assign wr_opt = access & PWRITE & is_reg(PADDR, `SWIC_IDX_OPTION);
	assign wr_pwr = access & PWRITE & is_reg(PADDR, `SWIC_IDX_PWR_CTL);

	always_comb
	begin
		pwr_rd           = '0;
		pwr_rd.parity_en = PARITY_CHECK_CFG;
		pwr_rd.parity_ok = pwr_ok_q[2];
		pwr_rd.por_ok    = pwr_ok_q[1];
		pwr_rd.bor_ok    = pwr_ok_q[0];
		rd_data          = 8'h00;
		if (is_reg(PADDR, `SWIC_IDX_STATUS))
		begin
			rd_data[`SWIC_BIT_TIMEOUT] = to_q;
			rd_data[`SWIC_BIT_PWRDOWN] = pd_q;
		end
		else if (is_reg(PADDR, `SWIC_IDX_IRQ_CTL))
			rd_data = ctl_q;
		else if (is_reg(PADDR, `SWIC_IDX_OPTION))
			rd_data[`SWIC_BIT_EDGE_SEL] = edge_sel_q;
		else if (is_reg(PADDR, `SWIC_IDX_PWR_CTL))
			rd_data = pwr_rd;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h00000000;
		end
		else
		begin
			PREADY  <= setup;
			PSLVERR <= setup & ~hit;
			if (setup)
				PRDATA <= {24'h000000, rd_data};
		end
	end

	// Boot marker asks the core to start from the reset vector.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
			boot_q <= 1'b1;
		else
			boot_q <= !master_clear_pin_s2_q;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			PC_LOAD  <= 1'b0;
			PC_VALUE <= `SWIC_VEC_RESET;
		end
		else
		begin
			PC_LOAD  <= boot_q | vector_now;
			PC_VALUE <= boot_q ? `SWIC_VEC_RESET : `SWIC_VEC_IRQ;
		end
	end

	// Core-facing controls, all registered.
	always_ff @(posedge SYS_CLK)
	begin
		if (!NRST)
		begin
			PHASE_Q1       <= 1'b0;
			IRQ_REQUEST    <= 1'b0;
			CORE_RESET     <= 1'b1;
			SLEEP_ACTIVE   <= 1'b0;
			IO_HOLD        <= 1'b0;
			OSC_DRIVE_EN   <= 1'b1;
			WATCHDOG_CLEAR <= 1'b0;
		end
		else
		begin
			PHASE_Q1       <= (phase_d == swic_pkg::PH_Q1);
			IRQ_REQUEST    <= pend;
			CORE_RESET     <= !master_clear_pin_s2_q;
			SLEEP_ACTIVE   <= (mode_d == swic_pkg::M_SLEEP);
			IO_HOLD        <= (mode_d == swic_pkg::M_SLEEP);
			OSC_DRIVE_EN   <= (mode_d != swic_pkg::M_SLEEP);
			WATCHDOG_CLEAR <= sleep_go;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	property p_ext_edge;
		(ext_edge && master_clear_pin_s2_q) |=> ctl_q.ext_flag;
	endproperty
	a_ext_edge: assert property (p_ext_edge)
		else $error("external edge did not set its flag");

	property p_tmr_ovf;
		(tmr_prev_q == `SWIC_TMR_MAX && TIMER_ZERO == `SWIC_TMR_ZERO &&
			master_clear_pin_s2_q)
			|=> ctl_q.timer_flag;
	endproperty
	a_tmr_ovf: assert property (p_tmr_ovf)
		else $error("timer roll-over did not set its flag");

	property p_port_chg;
		(arm_q[2] && port_s2_q != port_prev_q && master_clear_pin_s2_q &&
			!PORT_READ)
			|=> ctl_q.port_flag;
	endproperty
	a_port_chg: assert property (p_port_chg)
		else $error("port change did not set its flag");

	property p_sample_q1;
		(mode_q == swic_pkg::M_RUN && mode_d == swic_pkg::M_LAT)
			|-> phase_q == swic_pkg::PH_Q1 && ctl_q.global;
	endproperty
	a_sample_q1: assert property (p_sample_q1)
		else $error("interrupt taken outside the first phase");

	property p_latency;
		disable iff (!NRST || !master_clear_pin_s2_q)
		(mode_q == swic_pkg::M_RUN && mode_d == swic_pkg::M_LAT)
			|-> ##13 (PC_LOAD && PC_VALUE == `SWIC_VEC_IRQ);
	endproperty
	a_latency: assert property (p_latency)
		else $error("vector not loaded three cycles after sampling");

	property p_reset_pc;
		$rose(NRST) |-> ##1 (PC_LOAD && PC_VALUE == `SWIC_VEC_RESET);
	endproperty
	a_reset_pc: assert property (p_reset_pc)
		else $error("reset vector not loaded after reset");

	property p_sleep_entry;
		(mode_q == swic_pkg::M_RUN && SLEEP_EXEC && !pend && master_clear_pin_s2_q &&
			!WATCHDOG_TIMEOUT) |=> (SLEEP_ACTIVE && IO_HOLD &&
			!OSC_DRIVE_EN && WATCHDOG_CLEAR && !pd_q && to_q);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep entry effects missing");

	property p_sleep_nop;
		(mode_q == swic_pkg::M_RUN && SLEEP_EXEC && pend &&
			!WATCHDOG_TIMEOUT) |=> ($stable(pd_q) && $stable(to_q) &&
			!WATCHDOG_CLEAR && !SLEEP_ACTIVE);
	endproperty
	a_sleep_nop: assert property (p_sleep_nop)
		else $error("sleep with pending interrupt was not a no-op");

	property p_wake;
		(mode_q == swic_pkg::M_SLEEP && pend && master_clear_pin_s2_q)
			|=> !SLEEP_ACTIVE ##[1:4] mode_q == swic_pkg::M_RUN;
	endproperty
	a_wake: assert property (p_wake)
		else $error("enabled interrupt did not wake the device");

	property p_wdt_wake;
		(mode_q == swic_pkg::M_SLEEP && WATCHDOG_TIMEOUT && master_clear_pin_s2_q)
			|=> (!to_q && !SLEEP_ACTIVE);
	endproperty
	a_wdt_wake: assert property (p_wdt_wake)
		else $error("watchdog wake did not clear timeout flag");

	property p_no_global;
		(!ctl_q.global && mode_q == swic_pkg::M_RUN)
			|=> mode_q != swic_pkg::M_LAT;
	endproperty
	a_no_global: assert property (p_no_global)
		else $error("vectoring started with global enable clear");

	property p_pwr_read;
		(access && !PWRITE && is_reg(PADDR, `SWIC_IDX_PWR_CTL))
			|-> (PRDATA[7] == $past(PARITY_CHECK_CFG) &&
			PRDATA[6:3] == 4'h0);
	endproperty
	a_pwr_read: assert property (p_pwr_read)
		else $error("power control read shows wrong upper bits");

	c_sleep: cover property (WATCHDOG_CLEAR ##1 SLEEP_ACTIVE);
	c_nop: cover property (SLEEP_EXEC && pend && mode_q == swic_pkg::M_RUN);
	c_vector: cover property (PC_LOAD && PC_VALUE == `SWIC_VEC_IRQ);
	c_wake: cover property (mode_q == swic_pkg::M_WAKE);

endmodule : swic_top

/* File: verification/swic_pins.sv */
// Model of the pins around the block: interrupt pin, port inputs, clear pin.
// Assumes calls from the bench just after a rising edge of clk.
`timescale 1ns/10ps

module swic_pins (
	// Clock
	input  wire logic       clk,
	// Pins
	output logic            ext_irq_pin,
	output logic      [3:0] port_b_a,
	output logic            master_clear_n
);
	initial
	begin
		ext_irq_pin    = 1'b0;
		port_b_a       = 4'h0;
		master_clear_n = 1'b1;
	end

	// The delay lets a level change land promptly or late; the pins are
	// asynchronous to the block, which synchronises them itself.
	task automatic set_ext(input logic v, input int dly);
		repeat (dly) @(posedge clk);
		ext_irq_pin <= v;
	endtask : set_ext

	task automatic set_port(input logic [3:0] v, input int dly);
		repeat (dly) @(posedge clk);
		port_b_a <= v;
	endtask : set_port

	// The clear pin idles high; only a deliberate low resets the core.
	task automatic set_master_clear_pin(input logic v, input int dly);
		repeat (dly) @(posedge clk);
		master_clear_n <= v;
	endtask : set_master_clear_pin
endmodule : swic_pins

/* File: verification/sleep_wake_interrupt_control_test.sv */
// Self-checking bench of the sleep, wake and interrupt control block.
// Assumes the design files and the pin model are compiled first.
`timescale 1ns/10ps
`define TB_CHK(a, b) \
	begin \
		comparisons++; \
		if ((a) !== (b)) \
		begin \
			error_cnt++; \
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
		end \
	end

module sleep_wake_interrupt_control_test;
	typedef struct packed {
		logic [11:0] a;
		logic        w;
		logic [7:0]  d;
		logic [7:0]  x;
		logic        e;
	} swic_row_type;
	localparam logic [11:0] stat_a = 12'h00c;
	localparam logic [11:0] ctl_a  = 12'h02c;
	localparam logic [11:0] opt_a  = 12'h204;
	localparam logic [11:0] pwr_a  = 12'h238;
	localparam logic [11:0] bad_a  = 12'h3fc;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, ext_pin, master_clear_pin_n;
	logic [3:0]  port_b;
	logic        sleep_exec = 1'b0, periph_irq = 1'b0, wdt_tmo = 1'b0;
	logic        port_read = 1'b0, phase_q1;
	logic        bor_rst = 1'b0, par_rst = 1'b0, par_cfg = 1'b1;
	logic [7:0]  timer_zero = 8'h00;
	logic        irq_req, pc_load, core_rst, asleep, io_hold, osc_en;
	logic        wdt_clr;
	logic [12:0] pc_value;
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          n;
	swic_row_type rows [0:13];

	swic_pins pins (
		.clk(sys_clk), .ext_irq_pin(ext_pin), .port_b_a(port_b),
		.master_clear_n(master_clear_pin_n)
	);
	swic_top dut (
		.SYS_CLK(sys_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .EXT_IRQ_PIN(ext_pin),
		.PORT_B_A(port_b), .MASTER_CLEAR_N(master_clear_pin_n),
		.SLEEP_EXEC(sleep_exec), .PORT_READ(port_read),
		.TIMER_ZERO(timer_zero), .PERIPH_IRQ(periph_irq),
		.WATCHDOG_TIMEOUT(wdt_tmo), .BROWNOUT_RESET(bor_rst),
		.PARITY_ERROR_RESET(par_rst), .PARITY_CHECK_CFG(par_cfg),
		.PHASE_Q1(phase_q1), .IRQ_REQUEST(irq_req),
		.PC_LOAD(pc_load),
		.PC_VALUE(pc_value), .CORE_RESET(core_rst), .SLEEP_ACTIVE(asleep),
		.IO_HOLD(io_hold), .OSC_DRIVE_EN(osc_en), .WATCHDOG_CLEAR(wdt_clr)
	);

	initial
	begin
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// Well above the few hundred cycles the sequence needs.
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			test_done();
		end
	end

	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask : tick

	// One transfer; the trailing idle edge keeps psel from being assigned
	// twice in one time step when transfers follow each other.
	task automatic apb(input logic [11:0] a, input logic w,
		input logic [7:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		tick(1);
		penable <= 1'b1;
		do
		begin
			tick(1);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		tick(1);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(a, 1'b1, d, rd, err);
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] x);
		apb(a, 1'b0, 8'h00, rd, err);
		`TB_CHK(rd, {24'h0, x})
	endtask : rd_chk

	task automatic sleep_now();
		sleep_exec <= 1'b1;
		tick(1);
		sleep_exec <= 1'b0;
		tick(1);
	endtask : sleep_now

	task automatic wdt_now();
		wdt_tmo <= 1'b1;
		tick(1);
		wdt_tmo <= 1'b0;
		tick(2);
	endtask : wdt_now

	initial
	begin
		rows[0]  = '{stat_a, 1'b0, 8'h00, 8'h18, 1'b0};
		rows[1]  = '{ctl_a, 1'b0, 8'h00, 8'h00, 1'b0};
		rows[2]  = '{opt_a, 1'b0, 8'h00, 8'h40, 1'b0};
		rows[3]  = '{pwr_a, 1'b0, 8'h00, 8'h84, 1'b0};
		rows[4]  = '{bad_a, 1'b0, 8'h00, 8'h00, 1'b1};
		rows[5]  = '{bad_a, 1'b1, 8'hff, 8'h00, 1'b1};
		rows[6]  = '{stat_a, 1'b1, 8'h00, 8'h00, 1'b0};
		rows[7]  = '{stat_a, 1'b0, 8'h00, 8'h18, 1'b0};
		rows[8]  = '{pwr_a, 1'b1, 8'h07, 8'h00, 1'b0};
		rows[9]  = '{pwr_a, 1'b0, 8'h00, 8'h87, 1'b0};
		rows[10] = '{pwr_a, 1'b1, 8'h00, 8'h00, 1'b0};
		rows[11] = '{pwr_a, 1'b0, 8'h00, 8'h87, 1'b0};
		rows[12] = '{opt_a, 1'b1, 8'h00, 8'h00, 1'b0};
		rows[13] = '{opt_a, 1'b0, 8'h00, 8'h00, 1'b0};
		tick(12);
		nrst <= 1'b1;
		tick(2);
		foreach (rows[i])
		begin
			apb(rows[i].a, rows[i].w, rows[i].d, rd, err);
			if (!rows[i].w)
				`TB_CHK(rd, {24'h0, rows[i].x})
			`TB_CHK(err, rows[i].e)
		end
		$display("test register table done");
		// Falling mode first, so a rising edge must leave the flag clear.
		wr(ctl_a, 8'h10);
		pins.set_ext(1'b1, 1);
		tick(8);
		rd_chk(ctl_a, 8'h10);
		pins.set_ext(1'b0, 3);
		tick(8);
		rd_chk(ctl_a, 8'h12);
		`TB_CHK(irq_req, 1'b1)
		wr(ctl_a, 8'h10);
		wr(opt_a, 8'h40);
		pins.set_ext(1'b1, 1);
		tick(8);
		rd_chk(ctl_a, 8'h12);
		wr(ctl_a, 8'h00);
		tick(2);
		`TB_CHK(irq_req, 1'b0)
		wr(ctl_a, 8'h20);
		timer_zero <= 8'hff;
		tick(2);
		rd_chk(ctl_a, 8'h20);
		timer_zero <= 8'h00;
		tick(2);
		rd_chk(ctl_a, 8'h24);
		wr(ctl_a, 8'h08);
		pins.set_port(4'h5, 1);
		tick(8);
		rd_chk(ctl_a, 8'h09);
		// Line the port change up with a read in the second phase.
		wr(ctl_a, 8'h08);
		port_read <= 1'b1;
		n = 0;
		while (phase_q1 !== 1'b1 && n < 8)
		begin
			tick(1);
			n++;
		end
		pins.set_port(4'h0, 2);
		tick(8);
		port_read <= 1'b0;
		rd_chk(ctl_a, 8'h08);
		wr(ctl_a, 8'h40);
		periph_irq <= 1'b1;
		tick(3);
		`TB_CHK(irq_req, 1'b1)
		periph_irq <= 1'b0;
		$display("test flags done");
		pins.set_ext(1'b0, 1);
		tick(8);
		wr(ctl_a, 8'h90);
		pins.set_ext(1'b1, 1);
		n = 0;
		while (irq_req !== 1'b1 && n < 20)
		begin
			tick(1);
			n++;
		end
		n = 0;
		while (pc_load !== 1'b1 && n < 40)
		begin
			tick(1);
			n++;
		end
		`TB_CHK(pc_value, 13'h0004)
		`TB_CHK(n >= 12 && n <= 17, 1'b1)
		rd_chk(ctl_a, 8'h12);
		wr(ctl_a, 8'h00);
		$display("test vector done");
		tick(8);
		sleep_now();
		`TB_CHK({asleep, io_hold, osc_en, wdt_clr}, 4'b1101)
		rd_chk(stat_a, 8'h10);
		wdt_now();
		`TB_CHK({asleep, io_hold, osc_en}, 3'b001)
		rd_chk(stat_a, 8'h00);
		wr(ctl_a, 8'h08);
		tick(8);
		sleep_now();
		tick(2);
		`TB_CHK(asleep, 1'b1)
		pins.set_ext(1'b0, 1);
		pins.set_ext(1'b1, 4);
		tick(8);
		`TB_CHK(asleep, 1'b1)
		pins.set_port(4'ha, 1);
		n = 0;
		while (asleep !== 1'b0 && n < 12)
		begin
			tick(1);
			n++;
		end
		`TB_CHK(n < 12, 1'b1)
		rd_chk(stat_a, 8'h10);
		rd_chk(ctl_a, 8'h0b);
		wdt_now();
		tick(8);
		sleep_now();
		`TB_CHK({asleep, wdt_clr, osc_en}, 3'b001)
		rd_chk(stat_a, 8'h00);
		wr(ctl_a, 8'h00);
		$display("test sleep done");
		bor_rst <= 1'b1;
		tick(1);
		bor_rst <= 1'b0;
		tick(2);
		rd_chk(pwr_a, 8'h86);
		par_rst <= 1'b1;
		tick(1);
		par_rst <= 1'b0;
		tick(2);
		rd_chk(pwr_a, 8'h82);
		par_cfg <= 1'b0;
		tick(2);
		rd_chk(pwr_a, 8'h02);
		wr(ctl_a, 8'h38);
		wr(opt_a, 8'h00);
		pins.set_master_clear_pin(1'b0, 1);
		tick(6);
		`TB_CHK({core_rst, pc_value}, {1'b1, 13'h0000})
		pins.set_master_clear_pin(1'b1, 1);
		n = 0;
		while (core_rst !== 1'b0 && n < 10)
		begin
			tick(1);
			n++;
		end
		rd_chk(ctl_a, 8'h00);
		rd_chk(opt_a, 8'h40);
		rd_chk(pwr_a, 8'h02);
		nrst <= 1'b0;
		tick(4);
		nrst <= 1'b1;
		tick(2);
		`TB_CHK({core_rst, pc_load, pc_value}, {2'b01, 13'h0000})
		rd_chk(pwr_a, 8'h04);
		rd_chk(stat_a, 8'h18);
		rd_chk(ctl_a, 8'h00);
		$display("test resets done");
		test_done();
	end
endmodule : sleep_wake_interrupt_control_test
